// ---- smrs_pkg.sv ----
// Constants for the supply monitor and reset source logic.
// Assumes a single 200 MHz clock and a byte-wide special-function register port.
package smrs_pkg;
	localparam logic [7:0] SMRS_SUPPLY_CTRL_ADDR = 8'hff;
	localparam logic [7:0] SMRS_RESET_SRC_ADDR = 8'hef;
	localparam int SMRS_SUPPLY_EN_BIT = 7;
	localparam int SMRS_SUPPLY_STAT_BIT = 6;
	localparam int SMRS_PIN_FLAG_BIT = 0;
	localparam int SMRS_SUPPLY_SEL_BIT = 1;
	localparam int SMRS_MCD_FLAG_BIT = 2;
	localparam logic SMRS_SUPPLY_EN_RST = 1'b1;
	localparam logic SMRS_SUPPLY_SEL_RST = 1'b0;
	localparam logic SMRS_MCD_EN_RST = 1'b0;
	localparam int SMRS_CLK_MHZ = 200;
	localparam int SMRS_MCD_TIMEOUT_US = 100;
	localparam int SMRS_MCD_TIMEOUT_CYC = SMRS_MCD_TIMEOUT_US * SMRS_CLK_MHZ;
	localparam int SMRS_CNT_W = 16;
	localparam int SMRS_SYNC_W = 3;
	typedef enum logic [1:0] {
		SMRS_ST_RUN = 2'b00,
		SMRS_ST_HOLD = 2'b01,
		SMRS_ST_RELEASE = 2'b11
	} smrs_state_e;
endpackage : smrs_pkg

// ---- smrs_sync.sv ----
// Two-stage synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with one another.
`timescale 1ns/100ps
`default_nettype none
module smrs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule : smrs_sync
`default_nettype wire

// ---- smrs_top.sv ----
// Supply monitor control, external pin reset and missing-clock reset sources.
// Assumes RESETN is the power-on reset and that CLOCK is a free-running reference.
`timescale 1ns/100ps
`default_nettype none
module smrs_top
	import smrs_pkg::*;
#(
	parameter int unsigned MCD_TIMEOUT = smrs_pkg::SMRS_MCD_TIMEOUT_CYC
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic RST_PIN_N,
	input wire logic SYS_CLK_MON,
	input wire logic SUPPLY_ABOVE,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	output logic SUPPLY_MON_EN,
	output logic SYS_RESET_N
);
	import smrs_pkg::*;

	localparam logic [SMRS_CNT_W-1:0] TIMEOUT = SMRS_CNT_W'(MCD_TIMEOUT);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and register decode.

	logic [SMRS_SYNC_W-1:0] sync_bits;
	logic pin_low;
	logic clk_mon_s;
	logic supply_above_s;
	logic clk_mon_d_ff;
	logic edge_seen;
	logic [1:0] settle_ff;
	wire sync_fill = ~settle_ff[1];

	smrs_sync #(
		.WIDTH(SMRS_SYNC_W)
	) u_sync (
		.clk(CLOCK),
		.rst_n(RESETN),
		.async_in({SUPPLY_ABOVE, SYS_CLK_MON, ~RST_PIN_N}),
		.sync_out(sync_bits)
	);

	assign pin_low = sync_bits[0];
	assign clk_mon_s = sync_bits[1];
	assign supply_above_s = sync_bits[2];
	assign edge_seen = clk_mon_s ^ clk_mon_d_ff;

	// The synchronisers read idle for two edges after power-on. Reset is held until they
	// carry the real pin levels, so a pin held low cannot let reset go for one cycle.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			settle_ff <= 2'b00;
		end else begin
			settle_ff <= {settle_ff[0], 1'b1};
		end
	end

	wire sel_ctrl = (SFR_ADDR == SMRS_SUPPLY_CTRL_ADDR);
	wire sel_src = (SFR_ADDR == SMRS_RESET_SRC_ADDR);
	wire wr_ctrl = SFR_WR & sel_ctrl;
	wire wr_src = SFR_WR & sel_src;

	////////////////////////////////////////////////////////////////////////////////
	// Control bits. These live only in the power-on domain, so system resets keep them.

	logic supply_en_ff;
	logic supply_sel_ff;
	logic mcd_en_ff;

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			supply_en_ff <= SMRS_SUPPLY_EN_RST;
			supply_sel_ff <= SMRS_SUPPLY_SEL_RST;
			mcd_en_ff <= SMRS_MCD_EN_RST;
		end else begin
			if (wr_ctrl) begin
				supply_en_ff <= SFR_WDATA[SMRS_SUPPLY_EN_BIT];
			end
			if (wr_src) begin
				supply_sel_ff <= SFR_WDATA[SMRS_SUPPLY_SEL_BIT];
				mcd_en_ff <= SFR_WDATA[SMRS_MCD_FLAG_BIT];
			end
		end
	end

	assign SUPPLY_MON_EN = supply_en_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Missing-clock one-shot: counts reference cycles since the last monitored edge.

	logic [SMRS_CNT_W-1:0] mcd_cnt_ff;
	logic [SMRS_CNT_W-1:0] nxt_mcd_cnt;
	wire mcd_fault = mcd_en_ff & (mcd_cnt_ff == TIMEOUT);
	wire cnt_clear = ~mcd_en_ff | edge_seen;

	assign nxt_mcd_cnt = cnt_clear ? '0 :
		(mcd_fault ? mcd_cnt_ff : mcd_cnt_ff + SMRS_CNT_W'(1));

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			mcd_cnt_ff <= '0;
			clk_mon_d_ff <= 1'b0;
		end else begin
			mcd_cnt_ff <= nxt_mcd_cnt;
			clk_mon_d_ff <= clk_mon_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset sequencer. The block has no pin driver, so a detector reset leaves the pin alone.

	wire supply_fault = supply_en_ff & supply_sel_ff & ~supply_above_s;
	wire reset_req = sync_fill | pin_low | mcd_fault | supply_fault;

	smrs_state_e state_ff;
	smrs_state_e nxt_state;
	logic rst_out_ff;
	logic cause_pin_ff;
	logic cause_mcd_ff;
	logic pin_flag_ff;
	logic mcd_flag_ff;

	always_comb begin
		case (state_ff)
			SMRS_ST_RUN: begin
				nxt_state = reset_req ? SMRS_ST_HOLD : SMRS_ST_RUN;
			end
			SMRS_ST_HOLD: begin
				nxt_state = reset_req ? SMRS_ST_HOLD : SMRS_ST_RELEASE;
			end
			SMRS_ST_RELEASE: begin
				nxt_state = reset_req ? SMRS_ST_HOLD : SMRS_ST_RUN;
			end
			default: begin
				nxt_state = SMRS_ST_HOLD;
			end
		endcase
	end

	wire releasing = (state_ff == SMRS_ST_RELEASE);

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			state_ff <= SMRS_ST_HOLD;
			rst_out_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			rst_out_ff <= (nxt_state == SMRS_ST_RUN);
		end
	end

	// Causes accumulate during the hold; the flags only change in the release cycle,
	// so software running afterwards sees a steady picture.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			cause_pin_ff <= 1'b0;
			cause_mcd_ff <= 1'b0;
			pin_flag_ff <= 1'b0;
			mcd_flag_ff <= 1'b0;
		end else if (releasing) begin
			pin_flag_ff <= cause_pin_ff;
			mcd_flag_ff <= cause_mcd_ff;
			cause_pin_ff <= 1'b0;
			cause_mcd_ff <= 1'b0;
		end else begin
			cause_pin_ff <= cause_pin_ff | pin_low;
			cause_mcd_ff <= cause_mcd_ff | mcd_fault;
		end
	end

	assign SYS_RESET_N = rst_out_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Read path. Unused control bits read zero, which is one legal unspecified value.

	logic [7:0] rdata_ff;
	wire [7:0] ctrl_view = {supply_en_ff, supply_above_s, 6'h00};
	wire [7:0] src_view = {5'h00, mcd_flag_ff, supply_sel_ff, pin_flag_ff};
	wire [7:0] rd_mux = sel_ctrl ? ctrl_view : (sel_src ? src_view : 8'h00);

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			rdata_ff <= 8'h00;
		end else if (SFR_RD) begin
			rdata_ff <= rd_mux;
		end
	end

	assign SFR_RDATA = rdata_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESETN);

	pin_hold_a: assert property (pin_low |=> !SYS_RESET_N)
		else $error("Pin low did not hold reset.");
	supply_hold_a: assert property (supply_fault |=> !SYS_RESET_N [*2])
		else $error("Supply fault did not hold reset.");
	mcd_fire_a: assert property (mcd_fault |=> !SYS_RESET_N)
		else $error("Missing clock did not reset.");
	mcd_timeout_a: assert property ($rose(mcd_fault) |-> $past(mcd_cnt_ff) == TIMEOUT - 1'b1)
		else $error("Missing clock fired at wrong count.");
	mcd_retrig_a: assert property (mcd_en_ff && edge_seen |=> mcd_cnt_ff == '0 && !mcd_fault)
		else $error("Clock edge did not retrigger detector.");
	mcd_enable_a: assert property (wr_src |=> mcd_en_ff == $past(SFR_WDATA[2]))
		else $error("Detector enable not written.");
	pin_flag_a: assert property (releasing && cause_pin_ff |=> pin_flag_ff && (SYS_RESET_N || $past(reset_req)))
		else $error("Pin flag not set on release.");
	mcd_flag_a: assert property (releasing |=> mcd_flag_ff == $past(cause_mcd_ff))
		else $error("Missing clock flag wrong after release.");
	flags_stable_a: assert property (!releasing |=> $stable({pin_flag_ff, mcd_flag_ff}))
		else $error("Source flags changed outside release.");
	status_live_a: assert property (SFR_RD && sel_ctrl |=> SFR_RDATA[7:6] == $past({supply_en_ff, supply_above_s}) && SFR_RDATA[5:0] == 6'h00)
		else $error("Control read value wrong.");
	not_selected_a: assert property (state_ff == SMRS_ST_RUN && !supply_sel_ff && !pin_low && !mcd_fault |=> SYS_RESET_N)
		else $error("Unselected monitor caused reset.");

	pin_reset_c: cover property (releasing && cause_pin_ff);
	mcd_reset_c: cover property (releasing && cause_mcd_ff);
	supply_reset_c: cover property (supply_fault ##[1:20] !supply_fault);
endmodule : smrs_top
`default_nettype wire

// ---- smrs_partner.sv ----
// Far-side model: external reset pin, supply comparator and monitored system clock.
// Assumes the bench changes the three control inputs just after a CLOCK edge.
`timescale 1ns/100ps
`default_nettype none
module smrs_partner (
	input wire logic clock,
	input wire logic pin_hold,
	input wire logic clk_stall,
	input wire logic supply_low,
	output logic rst_pin_n,
	output var logic sys_clk_mon,
	output logic supply_above
);
	// The pin has a pull-up, so a released pin reads high.
	assign rst_pin_n = !pin_hold;
	assign supply_above = !supply_low;
	initial sys_clk_mon = 1'b0;
	// A stalled clock keeps its level, which is the fault the detector must catch.
	always @(posedge clock) begin
		if (!clk_stall) begin
			sys_clk_mon <= !sys_clk_mon;
		end
	end
endmodule : smrs_partner
`default_nettype wire

// ---- smrs_top_bench.sv ----
// Self-checking bench for the reset source block and its far-side model.
// Assumes a shortened detector timeout so that a stall is seen in tens of cycles.
`timescale 1ns/100ps
`default_nettype none
module smrs_top_bench;
	import smrs_pkg::*;
	localparam int TMO = 20;
	logic clk, rstn, pin_hold, clk_stall, supply_low, sfr_wr, sfr_rd;
	logic [7:0] sfr_addr, sfr_wdata;
	wire rst_pin_n, sys_clk_mon, supply_above, mon_en, sys_rst_n;
	wire [7:0] sfr_rdata;
	int num_errors = 0;
	int samples_checked = 0;
	smrs_partner smrs_partner_inst (.clock(clk), .pin_hold(pin_hold), .clk_stall(clk_stall),
		.supply_low(supply_low), .rst_pin_n(rst_pin_n), .sys_clk_mon(sys_clk_mon),
		.supply_above(supply_above));
	smrs_top #(.MCD_TIMEOUT(TMO)) smrs_top_inst (.CLOCK(clk), .RESETN(rstn),
		.RST_PIN_N(rst_pin_n), .SYS_CLK_MON(sys_clk_mon), .SUPPLY_ABOVE(supply_above),
		.SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata),
		.SFR_RDATA(sfr_rdata), .SUPPLY_MON_EN(mon_en), .SYS_RESET_N(sys_rst_n));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = !clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic step;
		@(posedge clk);
		#1;
	endtask : step
	task automatic results;
		if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		step;
		sfr_wr = 1'b0;
		step;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr = a;
		sfr_rd = 1'b1;
		step;
		sfr_rd = 1'b0;
		chk(sfr_rdata, exp);
		step;
	endtask : rdc
	// A wait that runs out of its bound ends the run at once.
	task automatic wait_rst(input logic lvl);
		for (int i = 0; i < 200 && sys_rst_n !== lvl; i++) step;
		chk({7'h00, sys_rst_n}, {7'h00, lvl});
		if (sys_rst_n !== lvl) results();
	endtask : wait_rst
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_por;
		rdc(SMRS_SUPPLY_CTRL_ADDR, 8'hc0);
		rdc(SMRS_RESET_SRC_ADDR, 8'h00);
		rdc(8'h10, 8'h00);
		chk({7'h00, mon_en}, 8'h01);
	endtask : t_por
	task automatic t_enable;
		wr(SMRS_SUPPLY_CTRL_ADDR, 8'h3f);
		rdc(SMRS_SUPPLY_CTRL_ADDR, 8'h40);
		chk({7'h00, mon_en}, 8'h00);
		supply_low = 1'b1;
		repeat (4) step;
		rdc(SMRS_SUPPLY_CTRL_ADDR, 8'h00);
		supply_low = 1'b0;
	endtask : t_enable
	task automatic t_pin;
		pin_hold = 1'b1;
		wait_rst(1'b0);
		repeat (30) step;
		chk({7'h00, sys_rst_n}, 8'h00);
		pin_hold = 1'b0;
		wait_rst(1'b1);
		rdc(SMRS_RESET_SRC_ADDR, 8'h01);
		rdc(SMRS_SUPPLY_CTRL_ADDR, 8'h40);
		wr(SMRS_SUPPLY_CTRL_ADDR, 8'h80);
	endtask : t_pin
	task automatic t_mcd;
		wr(SMRS_RESET_SRC_ADDR, 8'h04);
		clk_stall = 1'b1;
		repeat (TMO - 5) step;
		chk({7'h00, sys_rst_n}, 8'h01);
		wait_rst(1'b0);
		chk({7'h00, rst_pin_n}, 8'h01);
		clk_stall = 1'b0;
		wait_rst(1'b1);
		rdc(SMRS_RESET_SRC_ADDR, 8'h04);
		wr(SMRS_RESET_SRC_ADDR, 8'h00);
		rdc(SMRS_RESET_SRC_ADDR, 8'h04);
		clk_stall = 1'b1;
		repeat (3 * TMO) step;
		chk({7'h00, sys_rst_n}, 8'h01);
		clk_stall = 1'b0;
	endtask : t_mcd
	task automatic t_supply;
		wr(SMRS_SUPPLY_CTRL_ADDR, 8'h00);
		wr(SMRS_RESET_SRC_ADDR, 8'h02);
		supply_low = 1'b1;
		repeat (20) step;
		chk({7'h00, sys_rst_n}, 8'h01);
		wr(SMRS_RESET_SRC_ADDR, 8'h00);
		supply_low = 1'b0;
		wr(SMRS_SUPPLY_CTRL_ADDR, 8'h80);
		repeat (20) step;
		wr(SMRS_RESET_SRC_ADDR, 8'h02);
		chk({7'h00, sys_rst_n}, 8'h01);
		supply_low = 1'b1;
		wait_rst(1'b0);
		repeat (20) step;
		chk({7'h00, sys_rst_n}, 8'h00);
		supply_low = 1'b0;
		wait_rst(1'b1);
		rdc(SMRS_RESET_SRC_ADDR, 8'h02);
	endtask : t_supply
	// Power-on reset in mid-run with the pin already held low.
	task automatic t_por_pin;
		wr(SMRS_SUPPLY_CTRL_ADDR, 8'h00);
		pin_hold = 1'b1;
		rstn = 1'b0;
		step;
		rstn = 1'b1;
		repeat (8) begin
			step;
			chk({7'h00, sys_rst_n}, 8'h00);
		end
		pin_hold = 1'b0;
		wait_rst(1'b1);
		rdc(SMRS_SUPPLY_CTRL_ADDR, 8'hc0);
		rdc(SMRS_RESET_SRC_ADDR, 8'h01);
	endtask : t_por_pin
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rstn, pin_hold, clk_stall, supply_low, sfr_wr, sfr_rd} = 6'h00;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		repeat (12) @(posedge clk);
		#1;
		rstn = 1'b1;
		wait_rst(1'b1);
		t_por;
		t_enable;
		t_pin;
		t_mcd;
		t_supply;
		t_por_pin;
		results();
	end
endmodule : smrs_top_bench
`default_nettype wire
